// ---- hdl/ppw_top.sv ----
// Overview of operation
// - Read and write strobe pins serve the port only while the strobe enable is set.
// - High byte select pin serves the port only while its enable bit is set.
// - Low byte select pin serves the port only while its enable bit is set.
// - Two-bit wait field sets latch strobe width: one half to three and a half Tcy.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "ppw_defs.svh"
module ppw_top
   import ppw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        eng_enable_strobe,
   input  wire logic        eng_read_strobe,
   input  wire logic        eng_write_strobe,
   input  wire logic        eng_high_byte,
   input  wire logic        eng_low_byte,
   input  wire logic [6:0]  eng_upper_address,
   input  wire logic        latch_start,
   input  wire logic [11:0] gpio_out,
   input  wire logic [11:0] gpio_oe,
   output logic      [11:0] pin_out,
   output logic      [11:0] pin_oe,
   output logic             latch_strobe,
   output logic             latch_busy,
   output logic             latch_done
);

   ////////////////////////////////////////////////////////////////////////////////
   ppw_ctrl_t       ctrl;
   ppw_port_drive_t drive;
   logic            access;
   logic            hit_ctrl;
   logic            hit_stat;
   logic [31:0]     next_prdata;
   logic [11:0]     port_own;
   logic            timer_strobe;
   logic            timer_busy;
   logic            timer_done;

   assign access   = psel & penable & pready;
   assign hit_ctrl = (paddr == `PPW_CTRL_OFS);
   assign hit_stat = (paddr == `PPW_STAT_OFS);

   ////////////////////////////////////////////////////////////////////////////////
   // The slave answers one cycle into the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
      end
   end

   // Unmapped addresses answer with an error and zero data.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (ce) begin
         pslverr <= psel & penable & ~pready & ~hit_ctrl & ~hit_stat;
      end
   end

   always_comb begin
      next_prdata = 32'h00000000;
      if (hit_ctrl) begin
         next_prdata[15:0] = ctrl & `PPW_CTRL_WMASK;
      end else if (hit_stat) begin
         next_prdata[`PPW_STAT_BIT_BUSY] = timer_busy;
         next_prdata[`PPW_STAT_BIT_STRB] = timer_strobe;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (ce) begin
         if (psel & penable & ~pready & ~pwrite) begin
            prdata <= next_prdata;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Control register write; unimplemented bits stay zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `PPW_CTRL_RESET;
      end else if (ce) begin
         if (access & pwrite & hit_ctrl) begin
            ctrl <= pwdata[15:0] & `PPW_CTRL_WMASK;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign drive.enable_strobe    = eng_enable_strobe;
   assign drive.read_strobe      = eng_read_strobe;
   assign drive.write_strobe     = eng_write_strobe;
   assign drive.high_byte_select = eng_high_byte;
   assign drive.low_byte_select  = eng_low_byte;
   assign drive.upper_address    = eng_upper_address;

   // Pin order: enable strobe, read strobe, write strobe, high, low, upper address.
   assign port_own[11] = ctrl.write_strobe_pin_enable;
   assign port_own[10] = ctrl.rdwr_strobe_pin_enable;
   assign port_own[9]  = ctrl.rdwr_strobe_pin_enable;
   assign port_own[8]  = ctrl.high_byte_enable_pin_enable;
   assign port_own[7]  = ctrl.low_byte_enable_pin_enable;
   assign port_own[6:0] = ctrl.upper_address_pin_enables;

   ppw_pin_mux #(
      .NPINS(12)
   ) u_mux (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .port_own  (port_own),
      .port_value(drive),
      .gpio_out  (gpio_out),
      .gpio_oe   (gpio_oe),
      .pin_out   (pin_out),
      .pin_oe    (pin_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // latch strobe width
   ppw_latch_timer #(
      .CW(5)
   ) u_latch (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .start     (latch_start),
      .wait_field(ctrl.latch_strobe_wait_field),
      .hold_bit  (ctrl.address_hold_wait_bit),
      .strobe    (timer_strobe),
      .busy      (timer_busy),
      .done      (timer_done)
   );

   assign latch_strobe = timer_strobe;
   assign latch_busy   = timer_busy;
   assign latch_done   = timer_done;

endmodule

// ---- hdl/ppw_defs.svh ----
`ifndef PPW_DEFS_SVH
`define PPW_DEFS_SVH

`define PPW_CTRL_OFS       12'h000
`define PPW_STAT_OFS       12'h004

`define PPW_CTRL_RESET     16'h0000
`define PPW_CTRL_WMASK     16'hF77F

`define PPW_BIT_WREN       15
`define PPW_BIT_RDEN       14
`define PPW_BIT_BE1EN      13
`define PPW_BIT_BE0EN      12
`define PPW_BIT_WAIT_HI    10
`define PPW_BIT_WAIT_LO    9
`define PPW_BIT_HOLD       8
`define PPW_BIT_ADDR_HI    6
`define PPW_BIT_ADDR_LO    0

`define PPW_STAT_BIT_BUSY  0
`define PPW_STAT_BIT_STRB  1

`define PPW_CLK_PERIOD_NS  10
`define PPW_TCY_NS         40
`define PPW_TCY_CLKS       (`PPW_TCY_NS / `PPW_CLK_PERIOD_NS)
`define PPW_HALF_TCY_CLKS  (`PPW_TCY_CLKS / 2)
`define PPW_QTR_TCY_CLKS   (`PPW_TCY_CLKS / 4)

`endif

// ---- hdl/ppw_pkg.sv ----
package ppw_pkg;

   typedef struct packed {
      logic       write_strobe_pin_enable;
      logic       rdwr_strobe_pin_enable;
      logic       high_byte_enable_pin_enable;
      logic       low_byte_enable_pin_enable;
      logic       unused_11;
      logic [1:0] latch_strobe_wait_field;
      logic       address_hold_wait_bit;
      logic       unused_7;
      logic [6:0] upper_address_pin_enables;
   } ppw_ctrl_t;

   typedef struct packed {
      logic       enable_strobe;
      logic       read_strobe;
      logic       write_strobe;
      logic       high_byte_select;
      logic       low_byte_select;
      logic [6:0] upper_address;
   } ppw_port_drive_t;

   typedef enum logic [1:0] {
      PPW_LATCH_IDLE   = 2'b00,
      PPW_LATCH_STROBE = 2'b01,
      PPW_LATCH_HOLD   = 2'b10
   } ppw_latch_state_t;

endpackage

// ---- hdl/ppw_pin_mux.sv ----
`timescale 1ns/10ps
module ppw_pin_mux
   import ppw_pkg::*;
#(
   parameter int NPINS = 12
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   input  wire logic [NPINS-1:0] port_own,
   input  wire logic [NPINS-1:0] port_value,
   input  wire logic [NPINS-1:0] gpio_out,
   input  wire logic [NPINS-1:0] gpio_oe,
   output logic      [NPINS-1:0] pin_out,
   output logic      [NPINS-1:0] pin_oe
);

   // Each pin is either driven by the port or handed back to general purpose use.
   genvar i;
   generate
      for (i = 0; i < NPINS; i = i + 1) begin : g_pin
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_out[i] <= 1'b0;
               pin_oe[i]  <= 1'b0;
            end else if (ce) begin
               pin_out[i] <= port_own[i] ? port_value[i] : gpio_out[i];
               pin_oe[i]  <= port_own[i] ? 1'b1 : gpio_oe[i];
            end
         end
      end
   endgenerate

endmodule

// ---- hdl/ppw_latch_timer.sv ----
`timescale 1ns/10ps
`include "ppw_defs.svh"
module ppw_latch_timer
   import ppw_pkg::*;
#(
   parameter int CW = 5
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   input  wire logic       start,
   input  wire logic [1:0] wait_field,
   input  wire logic       hold_bit,
   output logic            strobe,
   output logic            busy,
   output logic            done
);

   ppw_latch_state_t state;
   logic [CW-1:0]    count;
   logic [CW-1:0]    width_clks;
   logic [CW-1:0]    hold_clks;

   // Strobe width is (2*field+1) half instruction cycles.
   assign width_clks = CW'((2 * int'(wait_field) + 1) * `PPW_HALF_TCY_CLKS);
   assign hold_clks  = hold_bit ? CW'(`PPW_TCY_CLKS + `PPW_QTR_TCY_CLKS)
                                : CW'(`PPW_QTR_TCY_CLKS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state  <= PPW_LATCH_IDLE;
         count  <= '0;
         strobe <= 1'b0;
         busy   <= 1'b0;
         done   <= 1'b0;
      end else if (ce) begin
         done <= 1'b0;
         unique case (state)
            PPW_LATCH_IDLE: begin
               if (start) begin
                  state  <= PPW_LATCH_STROBE;
                  count  <= width_clks - CW'(1);
                  strobe <= 1'b1;
                  busy   <= 1'b1;
               end
            end
            PPW_LATCH_STROBE: begin
               if (count == '0) begin
                  state  <= PPW_LATCH_HOLD;
                  count  <= hold_clks - CW'(1);
                  strobe <= 1'b0;
               end else begin
                  count <= count - CW'(1);
               end
            end
            PPW_LATCH_HOLD: begin
               if (count == '0) begin
                  state <= PPW_LATCH_IDLE;
                  busy  <= 1'b0;
                  done  <= 1'b1;
               end else begin
                  count <= count - CW'(1);
               end
            end
            default: begin
               state  <= PPW_LATCH_IDLE;
               strobe <= 1'b0;
               busy   <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ---- bench/ppw_assertions.sv ----
`timescale 1ns/10ps
module ppw_checker
   import ppw_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        eng_enable_strobe,
   input wire logic        eng_read_strobe,
   input wire logic        eng_write_strobe,
   input wire logic        eng_high_byte,
   input wire logic        eng_low_byte,
   input wire logic [6:0]  eng_upper_address,
   input wire logic        latch_start,
   input wire logic [11:0] gpio_out,
   input wire logic [11:0] gpio_oe,
   input wire logic [11:0] pin_out,
   input wire logic [11:0] pin_oe,
   input wire logic        latch_strobe,
   input wire logic        latch_busy,
   input wire logic        latch_done
);
   logic [15:0] sh;
   logic [3:0]  cnt;
   logic [3:0]  wexp;
   wire  [11:0] own = {sh[15], sh[14], sh[14], sh[13], sh[12], sh[6:0]};
   wire  [11:0] eng = {eng_enable_strobe, eng_read_strobe, eng_write_strobe,
                       eng_high_byte, eng_low_byte, eng_upper_address};
   wire  [11:0] xo  = (own & eng) | (~own & gpio_out);
   wire  [11:0] xe  = own | gpio_oe;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sh <= 16'h0000;
      else if (ce && psel && penable && pready && pwrite && paddr == 12'h000)
         sh <= pwdata[15:0] & 16'hF77F;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt  <= 4'h0;
         wexp <= 4'h0;
      end else if (ce && latch_start && !latch_busy) begin
         cnt  <= 4'h0;
         wexp <= {sh[10:9], 2'b00} + 4'h2;
      end else if (ce && latch_strobe)
         cnt <= cnt + 4'h1;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_strobe_pins: assert property (
      ce && presetn |=> {pin_out[10:9], pin_oe[10:9]} == $past({xo[10:9], xe[10:9]}))
      else $error("strobe pins wrong");
   a_high_select: assert property (
      ce && presetn |=> {pin_out[8], pin_oe[8]} == $past({xo[8], xe[8]}))
      else $error("high select pin wrong");
   a_low_select: assert property (
      ce && presetn |=> {pin_out[7], pin_oe[7]} == $past({xo[7], xe[7]}))
      else $error("low select pin wrong");
   a_upper_address: assert property (
      ce && presetn |=> {pin_out[6:0], pin_oe[6:0]} == $past({xo[6:0], xe[6:0]}))
      else $error("upper address pins wrong");
   a_strobe_width: assert property ($fell(latch_strobe) |-> cnt == wexp)
      else $error("latch strobe width wrong");
   a_strobe_start: assert property (
      ce && latch_start && !latch_busy |=> latch_strobe && latch_busy)
      else $error("latch strobe did not start");
   a_hold_short: assert property (
      $fell(latch_strobe) && !sh[8] |=> latch_done && !latch_busy)
      else $error("short hold wrong");
   a_hold_long: assert property (
      $fell(latch_strobe) && sh[8]
         |=> (latch_busy && !latch_done) [*4] ##1 (latch_done && !latch_busy))
      else $error("long hold wrong");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stood too long");
   a_ready_answer: assert property (ce && psel && penable && !pready |=> pready)
      else $error("ready did not answer");
   a_freeze_pins: assert property (!ce && presetn |=> $stable(pin_out) && $stable(pin_oe))
      else $error("pins moved while frozen");
   c_widest: cover property ($fell(latch_strobe) && wexp == 4'hE);
   c_all_owned: cover property (own == 12'hFFF);
   c_done: cover property (latch_done);
endmodule
bind ppw_top ppw_checker u_ppw_checker (.*);

// ---- bench/ppw_mem_model.sv ----
`timescale 1ns/10ps
module ppw_mem_model
   import ppw_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        latch_strobe,
   input  wire logic [11:0] pin_out,
   input  wire logic [11:0] pin_oe,
   output logic      [6:0]  addr_seen
);
   // Captures the driven upper address lines while the latch strobe is high.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         addr_seen <= 7'h00;
      else if (latch_strobe)
         addr_seen <= pin_out[6:0] & pin_oe[6:0];
   end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb
   import ppw_pkg::*;
;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000, gpio_out = 12'h3C6, gpio_oe = 12'h0A1, eng = 12'hA5A;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [11:0] pin_out, pin_oe;
   logic [6:0]  addr_seen;
   logic        pready, pslverr, rerr, latch_start = 1'b0, latch_strobe, latch_busy, latch_done;
   logic        ce = 1'b1;
   int          errors = 0, comparisons = 0, n, k;
   always #5 pclk = ~pclk;
   ppw_top u_ppw_top (.*, .eng_enable_strobe(eng[11]), .eng_read_strobe(eng[10]),
      .eng_write_strobe(eng[9]), .eng_high_byte(eng[8]), .eng_low_byte(eng[7]),
      .eng_upper_address(eng[6:0]));
   ppw_mem_model u_ppw_mem_model (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         errors++;
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic setpins(input logic [15:0] c);
      logic [11:0] own;
      own = {c[15], c[14], c[14], c[13], c[12], c[6:0]};
      apb(1'b1, 12'h000, {16'h0000, c});
      repeat (2) @(posedge pclk);
      chk({8'h00, pin_out, pin_oe}, {8'h00, (own & eng) | (~own & gpio_out), own | gpio_oe});
   endtask
   task automatic conclude;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      conclude;
   end
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h0);
      apb(1'b1, 12'h000, 32'hFFFF_FFFF);
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h0000_F77F);
      apb(1'b1, 12'h004, 32'hFFFF_FFFF);
      chk({31'h0, rerr}, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rdat, 32'h0000_F77F);
      apb(1'b0, 12'h008, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      $display("test regs done");
      for (int j = 0; j < 11; j++)
         setpins(j < 4 ? 16'h8000 >> j : 16'h0001 << (j - 4));
      setpins(16'hF07F);
      setpins(16'h0000);
      ce       <= 1'b0;
      gpio_out <= 12'h5A5;
      repeat (3) @(posedge pclk);
      chk({20'h0, pin_out}, 32'h0000_03C6);
      ce <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({20'h0, pin_out}, 32'h0000_05A5);
      $display("test pins done");
      for (int f = 0; f < 4; f++) begin
         apb(1'b1, 12'h000, {21'h0, f[1:0], f[0], 8'h7F});
         latch_start <= 1'b1;
         @(posedge pclk);
         latch_start <= 1'b0;
         n = 0;
         k = 0;
         while (latch_done !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k++;
            if (latch_strobe === 1'b1)
               n++;
         end
         chk(n, 2 + 4 * f);
         chk(k, 2 + 4 * f + (f[0] ? 6 : 2));
         chk({31'h0, latch_done}, 32'h1);
         chk({25'h0, addr_seen}, {25'h0, eng[6:0]});
      end
      latch_start <= 1'b1;
      @(posedge pclk);
      latch_start <= 1'b0;
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0000_0003);
      repeat (30) @(posedge pclk);
      apb(1'b0, 12'h004, 32'h0);
      chk(rdat, 32'h0000_0000);
      $display("test latch done");
      conclude;
   end
endmodule
